// *** pd_event_defs.svh ***
// Constants for the transmit and receive event flag block
// ==========================================================
// Overview of operation
// [RULE1] Set transmit-failure bit 1 on acknowledge timeout or retry limit exceeded.
// [RULE2] Without auto retry, timer expiry still raises transmit-failure when timer enabled.
// [RULE3] Software disables the acknowledge timer itself when GoodCRC arrives.
// [RULE4] Only in auto retry mode, set acknowledged bit 0 on completed request.
// [RULE5] No acknowledged flag for hard or cable reset sends; ended flag covers them.
// [RULE6] Without auto retry, software relies on the transmission-ended flag.
// [RULE7] Receive flags set only by hardware; software clears each by writing one.
// [RULE8] Receive flag requests interrupt only when its enable bit is set.
// [RULE9] Bit 7 reflects receive FIFO not empty, read only.
// [RULE10] Line-idle flag at bit 6, resets to one, an event latch.
// [RULE11] Enabling line-idle interrupt while idle sets flag now, else at idle.
// [RULE12] Line-idle flagging works only while MAC clocks are enabled.
// [RULE13] Cable reset sets bit 5, hard reset bit 3; bit 4 reads zero.
`ifndef PD_EVENT_DEFS_SVH
`define PD_EVENT_DEFS_SVH

// ==========================================================
// Register word addresses (byte address = index * 4)
`define RX_FLAGS_INDEX 16'h1a82
`define TX_FLAGS_INDEX 16'h1a81
`define RX_ENABLE_INDEX 16'h1a90
`define TX_ENABLE_INDEX 16'h1a91
`define CONTROL_INDEX 16'h1a92

// ==========================================================
// Field positions
`define TX_ACKED_BIT 0
`define TX_FAILED_BIT 1
`define TX_ENDED_BIT 3
`define RX_HARD_RST_BIT 3
`define RX_RSVD_BIT 4
`define RX_CABLE_RST_BIT 5
`define RX_IDLE_BIT 6
`define RX_FIFO_BIT 7
`define CTL_AUTO_RETRY_BIT 0
`define CTL_ACK_TIMER_BIT 1
`define CTL_CLOCKS_ON_BIT 2

// ==========================================================
// Reset values and used-bit masks
`define TX_FLAGS_RESET 8'h00
`define RX_FLAGS_RESET 8'h40
`define ENABLE_RESET 8'h00
`define CONTROL_RESET 8'h04
`define TX_FLAGS_MASK 8'h0b
`define RX_FLAGS_MASK 8'h68

`endif

// *** pd_event_if.sv ***
// Interface joining the top to its flag register module
`timescale 1ns/1ps
`default_nettype none
interface pd_flag_if;
  import pd_event_pkg::*;
  flag_byte_t set_pulses;
  flag_byte_t clear_mask;
  flag_byte_t flags;
  modport owner (input set_pulses, input clear_mask, output flags);
  modport user (output set_pulses, output clear_mask, input flags);
endinterface : pd_flag_if
`default_nettype wire

// *** pd_event_pkg.sv ***
// Types shared by the event flag block
package pd_event_pkg;
  typedef logic [7:0] flag_byte_t;
  typedef enum logic [1:0] {
    access_idle,
    access_ack
  } bus_state_t;
endpackage : pd_event_pkg

// *** pd_event_source.sv ***
// Strobe source standing in for the transmit and receive machinery
`timescale 1ns/1ps
`default_nettype none
module pd_event_source (
  input wire logic i_clock,
  input wire logic i_fire,
  input wire logic [2:0] i_kind,
  output var logic [5:0] o_pulse = 6'h00
);
  // Strobes follow i_fire one cycle later and last while it is high; one cycle when fired for one, as the real machinery pulses
  always @(posedge i_clock) begin
    o_pulse <= i_fire ? 6'h01 << i_kind : 6'h00;
  end
endmodule : pd_event_source
`default_nettype wire

// *** pd_flag_reg.sv ***
// One byte of sticky write-one-to-clear event flags
`timescale 1ns/1ps
`default_nettype none
`include "pd_event_defs.svh"
module pd_flag_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] USED_MASK = 8'hff
) (
  input wire logic i_clock,
  input wire logic i_rst,
  pd_flag_if.owner flag_port
);
  import pd_event_pkg::*;

  // ==========================================================
  // Flags, set wins over a same-cycle clear
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_flag
      if (USED_MASK[g]) begin : g_used
        logic flag;
        always_ff @(posedge i_clock or posedge i_rst) begin
          if (i_rst) begin
            flag <= RESET_VALUE[g];
          end else if (flag_port.set_pulses[g]) begin
            flag <= 1'b1; // RULE7
          end else if (flag_port.clear_mask[g]) begin
            flag <= 1'b0; // RULE7
          end
        end
        assign flag_port.flags[g] = flag;
      end else begin : g_unused
        assign flag_port.flags[g] = 1'b0;
      end
    end
  endgenerate
endmodule : pd_flag_reg
`default_nettype wire

// *** pd_flags_asserts.sv ***
// Port-level checker for the event flag block
`timescale 1ns/1ps
`default_nettype none
`include "pd_event_defs.svh"
module pd_flags_asserts (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [17:0] i_wb_adr,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic i_tx_request_done,
  input wire logic i_tx_ack_timeout,
  input wire logic i_tx_retry_exhausted,
  input wire logic i_tx_no_goodcrc,
  input wire logic i_rx_fifo_not_empty,
  input wire logic i_rx_hard_reset,
  input wire logic i_rx_cable_reset,
  input wire logic o_auto_retry,
  input wire logic o_ack_timer_enable,
  input wire logic o_irq
);
  // ==========================================================
  // Request decode
  logic take;
  logic rd_rx;
  logic rd_tx;
  assign take = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign rd_rx = take && !i_wb_we && i_wb_adr == {`RX_FLAGS_INDEX, 2'b00};
  assign rd_tx = take && !i_wb_we && i_wb_adr == {`TX_FLAGS_INDEX, 2'b00};
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  // ==========================================================
  // Properties
  a_ack_follows: assert property (take |=> o_wb_ack) else $error("no ack one cycle after request");
  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
  a_upper_zero: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0) else $error("upper read bits set");
  a_fifo_live: assert property (rd_rx |=> o_wb_dat[7] == $past(i_rx_fifo_not_empty)) else $error("fifo bit");
  a_reserved_zero: assert property (rd_rx |=> !o_wb_dat[4]) else $error("reserved bit set");
  a_hard_sets: assert property (rd_rx && $past(i_rx_hard_reset) |=> o_wb_dat[3]) else $error("hard flag");
  a_cable_sets: assert property (rd_rx && $past(i_rx_cable_reset) |=> o_wb_dat[5]) else $error("cable flag");
  a_acked_sets: assert property (rd_tx && $past(i_tx_request_done && o_auto_retry && !i_tx_no_goodcrc)
    |=> o_wb_dat[0]) else $error("acked flag");
  a_failed_sets: assert property (rd_tx && $past(o_auto_retry ? (i_tx_ack_timeout || i_tx_retry_exhausted)
    : (o_ack_timer_enable && i_tx_ack_timeout)) |=> o_wb_dat[1]) else $error("failed flag");
  c_hard_read: cover property (rd_rx ##1 o_wb_dat[3]);
  c_fail_read: cover property (rd_tx ##1 o_wb_dat[1]);
  c_irq_up: cover property (o_irq);
endmodule : pd_flags_asserts

bind pd_mac_txrx_event_flags pd_flags_asserts chk (.i_clock, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
  .o_wb_dat, .o_wb_ack, .i_tx_request_done, .i_tx_ack_timeout, .i_tx_retry_exhausted, .i_tx_no_goodcrc,
  .i_rx_fifo_not_empty, .i_rx_hard_reset, .i_rx_cable_reset, .o_auto_retry, .o_ack_timer_enable, .o_irq);
`default_nettype wire

// *** pd_mac_txrx_event_flags.sv ***
// Transmit and receive event flags with Wishbone access and interrupt
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pd_event_defs.svh"
module pd_mac_txrx_event_flags (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [17:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_tx_request_done,
  input wire logic i_tx_ack_timeout,
  input wire logic i_tx_retry_exhausted,
  input wire logic i_tx_no_goodcrc,
  input wire logic i_tx_ended,
  input wire logic i_rx_fifo_not_empty,
  input wire logic i_line_idle,
  input wire logic i_rx_hard_reset,
  input wire logic i_rx_cable_reset,
  output logic o_auto_retry,
  output logic o_ack_timer_enable,
  output logic o_irq
);
  import pd_event_pkg::*;

  pd_flag_if tx_if ();
  pd_flag_if rx_if ();

  flag_byte_t tx_enable;
  flag_byte_t rx_enable;
  flag_byte_t control;
  logic fifo_seen;
  logic idle_prev_enable;
  bus_state_t bus_state;

  // ==========================================================
  // Bus decode
  logic [15:0] word_index;
  logic access;
  logic write_low;
  assign word_index = i_wb_adr[17:2];
  assign access = i_wb_cyc && i_wb_stb && (bus_state == access_idle);
  assign write_low = access && i_wb_we && i_wb_sel[0];

  logic clocks_on;
  logic auto_retry;
  logic ack_timer;
  assign clocks_on = control[`CTL_CLOCKS_ON_BIT];
  assign auto_retry = control[`CTL_AUTO_RETRY_BIT];
  assign ack_timer = control[`CTL_ACK_TIMER_BIT];

  // ==========================================================
  // Event set terms
  logic tx_fail_event;
  logic tx_ack_event;
  logic idle_enable_rise;
  logic idle_event;
  assign tx_fail_event = (auto_retry && (i_tx_ack_timeout || i_tx_retry_exhausted)) || // RULE1
    (!auto_retry && ack_timer && i_tx_ack_timeout); // RULE2
  // Software must stop the timer after GoodCRC itself when retry is off
  assign tx_ack_event = auto_retry && i_tx_request_done && !i_tx_no_goodcrc; // RULE4 RULE5
  assign idle_enable_rise = rx_enable[`RX_IDLE_BIT] && !idle_prev_enable;
  // Enabling while idle flags at once; otherwise the falling busy edge does
  assign idle_event = clocks_on && i_line_idle && (idle_enable_rise || !fifo_seen); // RULE10 RULE11 RULE12

  always_comb begin
    tx_if.set_pulses = 8'h00;
    tx_if.set_pulses[`TX_FAILED_BIT] = tx_fail_event;
    tx_if.set_pulses[`TX_ACKED_BIT] = tx_ack_event;
    tx_if.set_pulses[`TX_ENDED_BIT] = i_tx_ended;
    tx_if.clear_mask = (write_low && word_index == `TX_FLAGS_INDEX) ? i_wb_dat[7:0] : 8'h00;
  end

  always_comb begin
    rx_if.set_pulses = 8'h00;
    rx_if.set_pulses[`RX_IDLE_BIT] = idle_event;
    rx_if.set_pulses[`RX_CABLE_RST_BIT] = i_rx_cable_reset; // RULE13
    rx_if.set_pulses[`RX_HARD_RST_BIT] = i_rx_hard_reset; // RULE13
    rx_if.clear_mask = (write_low && word_index == `RX_FLAGS_INDEX) ? i_wb_dat[7:0] : 8'h00; // RULE7
  end

  pd_flag_reg #(
    .RESET_VALUE(`TX_FLAGS_RESET),
    .USED_MASK(`TX_FLAGS_MASK)
  ) u_tx_flags (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .flag_port(tx_if.owner)
  );

  pd_flag_reg #(
    .RESET_VALUE(`RX_FLAGS_RESET),
    .USED_MASK(`RX_FLAGS_MASK)
  ) u_rx_flags (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .flag_port(rx_if.owner)
  );

  // ==========================================================
  // Line activity history: idle after busy is an event, not a level
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      fifo_seen <= 1'b1;
      idle_prev_enable <= 1'b0;
    end else begin
      if (clocks_on) begin
        fifo_seen <= i_line_idle; // RULE12
      end
      idle_prev_enable <= rx_enable[`RX_IDLE_BIT];
    end
  end

  // ==========================================================
  // Software writable registers
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      tx_enable <= `ENABLE_RESET;
      rx_enable <= `ENABLE_RESET;
      control <= `CONTROL_RESET;
    end else if (write_low) begin
      if (word_index == `TX_ENABLE_INDEX) begin
        tx_enable <= i_wb_dat[7:0];
      end
      if (word_index == `RX_ENABLE_INDEX) begin
        rx_enable <= i_wb_dat[7:0];
      end
      if (word_index == `CONTROL_INDEX) begin
        control <= i_wb_dat[7:0];
      end
    end
  end

  // ==========================================================
  // Readback view of receive flags with live FIFO bit
  flag_byte_t rx_view;
  always_comb begin
    rx_view = rx_if.flags;
    rx_view[`RX_FIFO_BIT] = i_rx_fifo_not_empty; // RULE9
    rx_view[`RX_RSVD_BIT] = 1'b0; // RULE13
  end

  flag_byte_t read_byte;
  always_comb begin
    unique case (word_index)
      `TX_FLAGS_INDEX: read_byte = tx_if.flags;
      `RX_FLAGS_INDEX: read_byte = rx_view;
      `TX_ENABLE_INDEX: read_byte = tx_enable;
      `RX_ENABLE_INDEX: read_byte = rx_enable;
      `CONTROL_INDEX: read_byte = control;
      default: read_byte = 8'h00;
    endcase
  end

  // ==========================================================
  // Wishbone answer: one wait cycle, ack for one cycle
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      bus_state <= access_idle;
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      unique case (bus_state)
        access_idle: begin
          if (access) begin
            bus_state <= access_ack;
            o_wb_ack <= 1'b1;
            o_wb_dat <= {24'h00_0000, read_byte};
          end
        end
        access_ack: begin
          bus_state <= access_idle;
          o_wb_ack <= 1'b0;
        end
        default: begin
          bus_state <= access_idle;
          o_wb_ack <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Interrupt and control outputs
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_irq <= 1'b0;
      o_auto_retry <= 1'b0;
      o_ack_timer_enable <= 1'b0;
    end else begin
      o_irq <= |(rx_view & rx_enable) || |(tx_if.flags & tx_enable); // RULE8
      o_auto_retry <= auto_retry;
      o_ack_timer_enable <= ack_timer;
    end
  end
endmodule : pd_mac_txrx_event_flags
`default_nettype wire

// *** pd_mac_txrx_event_flags_bench.sv ***
// Self-checking bench for the transmit and receive event flags
`timescale 1ns/1ps
`default_nettype none
`include "pd_event_defs.svh"
module pd_mac_txrx_event_flags_bench;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_wb_cyc = 1'b0;
  logic i_wb_stb = 1'b0;
  logic i_wb_we = 1'b0;
  logic [17:0] i_wb_adr = 18'h0;
  logic [3:0] i_wb_sel = 4'hf;
  logic [31:0] i_wb_dat = 32'h0;
  logic [31:0] o_wb_dat;
  logic o_wb_ack, o_auto_retry, o_ack_timer_enable, o_irq;
  logic i_tx_no_goodcrc = 1'b0;
  logic i_rx_fifo_not_empty = 1'b0;
  logic i_line_idle = 1'b1;
  logic fire = 1'b0;
  logic [2:0] kind = 3'h0;
  logic [5:0] pulse;
  logic [31:0] seed = 32'h4860;
  logic [31:0] ent;
  logic [31:0] exp_q[$];
  // Entry: control, event kind, no-goodcrc, expected tx, expected rx
  logic [31:0] table_e [10] = '{32'h05000100, 32'h05010000, 32'h04300800, 32'h05100200, 32'h05200200,
    32'h06100200, 32'h04100000, 32'h04000000, 32'h05400008, 32'h05500020};
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;
  pd_event_source partner (.i_clock, .i_fire(fire), .i_kind(kind), .o_pulse(pulse));
  pd_mac_txrx_event_flags DUT (.i_clock, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel,
    .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_tx_request_done(pulse[0]), .i_tx_ack_timeout(pulse[1]),
    .i_tx_retry_exhausted(pulse[2]), .i_tx_no_goodcrc, .i_tx_ended(pulse[3]), .i_rx_fifo_not_empty,
    .i_line_idle, .i_rx_hard_reset(pulse[4]), .i_rx_cable_reset(pulse[5]), .o_auto_retry,
    .o_ack_timer_enable, .o_irq);
  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp
  task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d);
    @(posedge i_clock);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_adr <= {idx, 2'b00};
    i_wb_dat <= {24'h0, d};
    // Hold the request until the edge that sees ack high, then release there
    do @(posedge i_clock); while (o_wb_ack !== 1'b1);
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask : bus
  task automatic rd(input logic [15:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b0, idx, 8'h00);
  endtask : rd
  task automatic chk_irq(input logic e);
    @(negedge i_clock);
    cmp({31'h0, e}, {31'h0, o_irq});
  endtask : chk_irq
  task automatic ev(input logic [2:0] k);
    @(posedge i_clock);
    fire <= 1'b1;
    kind <= k;
    @(posedge i_clock);
    fire <= 1'b0;
  endtask : ev
  task automatic final_report;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  // ==========================================================
  // Clock, monitor, timeout
  initial begin
    forever #20 i_clock = ~i_clock;
  end
  // Read data is taken at the same edge that samples ack high
  always @(posedge i_clock) begin
    if (o_wb_ack === 1'b1 && i_wb_we === 1'b0) cmp(exp_q.pop_front(), o_wb_dat);
  end
  always @(posedge i_clock) begin
    cycles++;
    if (cycles > 3000) begin
      err_total++;
      final_report();
    end
  end
  // ==========================================================
  // Scenarios
  initial begin
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    rd(`RX_FLAGS_INDEX, 8'h40);
    rd(`CONTROL_INDEX, 8'h04);
    bus(1'b1, `RX_FLAGS_INDEX, 8'h40);
    rd(`RX_FLAGS_INDEX, 8'h00);
    @(posedge i_clock) i_line_idle <= 1'b0;
    @(posedge i_clock) i_line_idle <= 1'b1;
    rd(`RX_FLAGS_INDEX, 8'h40);
    bus(1'b1, `RX_FLAGS_INDEX, 8'h40);
    bus(1'b1, `RX_ENABLE_INDEX, 8'h40);
    rd(`RX_FLAGS_INDEX, 8'h40);
    chk_irq(1'b1);
    bus(1'b1, `RX_ENABLE_INDEX, 8'h00);
    chk_irq(1'b0);
    bus(1'b1, `CONTROL_INDEX, 8'h00);
    bus(1'b1, `RX_FLAGS_INDEX, 8'h40);
    @(posedge i_clock) i_line_idle <= 1'b0;
    @(posedge i_clock) i_line_idle <= 1'b1;
    rd(`RX_FLAGS_INDEX, 8'h00);
    foreach (table_e[n]) begin
      ent = table_e[n];
      bus(1'b1, `CONTROL_INDEX, ent[31:24]);
      bus(1'b1, `TX_FLAGS_INDEX, 8'hff);
      bus(1'b1, `RX_FLAGS_INDEX, 8'hff);
      seed = lfsr(seed);
      i_rx_fifo_not_empty <= seed[0];
      i_tx_no_goodcrc <= ent[16];
      ev(ent[22:20]);
      if (ent[22]) rd(`RX_FLAGS_INDEX, ent[7:0] | {seed[0], 7'h00});
      else rd(`TX_FLAGS_INDEX, ent[15:8]);
      chk_irq(1'b0);
    end
    bus(1'b1, `RX_ENABLE_INDEX, 8'h20);
    chk_irq(1'b1);
    bus(1'b1, `RX_FLAGS_INDEX, 8'h20);
    chk_irq(1'b0);
    bus(1'b1, 16'h1aa0, seed[7:0]);
    rd(16'h1aa0, 8'h00);
    final_report();
  end
endmodule : pd_mac_txrx_event_flags_bench
`default_nettype wire
